// >>> rtl/dpm_pkg.sv
// Purpose: Shared constants and types for the decoder 1 pin multiplexer.
// Assumes: Three pins: phase B, index and home of the second quadrature decoder.
// Notes:   Pin index 0 is phase B, 1 is index, 2 is home.
package dpm_pkg;

	// Number of multiplexed pins
	localparam int unsigned DPM_NUM_PINS     = 3;

	// Pin positions inside every per-pin vector
	localparam int unsigned DPM_PIN_PHASE_B  = 0;
	localparam int unsigned DPM_PIN_INDEX    = 1;
	localparam int unsigned DPM_PIN_HOME     = 2;

	// Port C pull-up register: width and the bit that serves pin 0
	localparam int unsigned DPM_PUR_W        = 4;
	localparam int unsigned DPM_PUR_LSB      = 1;

	// Reset value of the per-pin pull-up enables (all on)
	localparam logic [2:0]  DPM_PULL_RST     = 3'h7;

	// Reset value of pin drive and output enables
	localparam logic [2:0]  DPM_PIN_OUT_RST  = 3'h0;
	localparam logic [2:0]  DPM_PIN_OE_RST   = 3'h0;

	// Level handed to a function whose pin is routed elsewhere
	localparam logic        DPM_RX_IDLE      = 1'b1;
	localparam logic [2:0]  DPM_RX_IDLE_V    = 3'h7;

	// Slave select is active low
	localparam logic        DPM_SS_ACTIVE    = 1'b0;

	// Constant drive levels
	localparam logic        DPM_DRV_OFF      = 1'b0;

	// Function that a pin carries at a given moment
	typedef enum logic [2:0] {
		DPM_FN_DECODER,
		DPM_FN_TIMER,
		DPM_FN_SPI,
		DPM_FN_GPIO,
		DPM_FN_NONE
	} dpm_fn_e;

endpackage

// >>> rtl/dpm_pin_cell.sv
// Purpose: Function selection and drive for one multiplexed pin.
// Assumes: All inputs are synchronous; the parent registers the outputs.
// Notes:   Purely combinational; priority is SPI, then GPIO, then timer, then decoder.
module dpm_pin_cell
	import dpm_pkg::*;
#(
	parameter bit FULL_FEATURED = 1'b1
) (
	input  wire logic    alt_select,
	input  wire logic    periph_en,
	input  wire logic    timer_select,
	input  wire logic    gpio_out,
	input  wire logic    gpio_dir_out,
	input  wire logic    timer_out,
	input  wire logic    timer_oe,
	input  wire logic    spi_out,
	input  wire logic    spi_oe,
	output dpm_fn_e      fn,
	output logic         pin_out,
	output logic         pin_oe
);

	// Chosen function for this pin
	dpm_fn_e fn_w;
	// Decoder is only offered on the full variant; otherwise the default is dead
	wire dpm_fn_e dflt_w = dpm_fn_e'(FULL_FEATURED ? DPM_FN_DECODER : DPM_FN_NONE);

	assign fn_w = dpm_fn_e'(alt_select   ? DPM_FN_SPI :
	                        !periph_en   ? DPM_FN_GPIO :
	                        timer_select ? DPM_FN_TIMER : dflt_w);

	assign fn = fn_w;

	// Drive select: decoder and unused pins are inputs only
	always_comb begin
		pin_out = DPM_DRV_OFF;
		pin_oe  = DPM_DRV_OFF;
		unique case (fn_w)
			DPM_FN_GPIO: begin
				pin_out = gpio_out;
				pin_oe  = gpio_dir_out;
			end
			DPM_FN_TIMER: begin
				pin_out = timer_out;
				pin_oe  = timer_oe;
			end
			DPM_FN_SPI: begin
				pin_out = spi_out;
				pin_oe  = spi_oe;
			end
			// Decoder or no function: never drive
			DPM_FN_DECODER, DPM_FN_NONE: begin
				pin_out = DPM_DRV_OFF;
				pin_oe  = DPM_DRV_OFF;
			end
		endcase
	end

endmodule // dpm_pin_cell

// >>> rtl/dpm_pin_mux.sv
// Purpose: Pin multiplexer for the phase B, index and home pins of decoder 1.
// Assumes: One clock, asynchronous active-low reset, synchronous pin inputs.
// Notes:   Every output is registered, so each path adds one clock of latency.
//
// Functional notes
// - Phase B alt routes SPI master-out
// - Select_a routes SPI master-in
// - Select_b routes SPI slave select
// - Full variant defaults to decoder inputs
// - Pull-ups on at reset, cleared bits disable
// - GPIO pins individually input or output
// - Pins carry timer B channels 1-3
// - Master-out data leads slave sample half-cycle
// - Master-in data leads master sample half-cycle
// - Unselected slave leaves master-in undriven
// - Slave select: arbitration in master, select in slave
module dpm_pin_mux
	import dpm_pkg::*;
#(
	parameter bit FULL_FEATURED = 1'b1  // 0 selects the reduced variant
) (
	input  wire logic                 clock,
	input  wire logic                 reset_n,
	// Pad side
	input  wire logic [2:0]           pin_in,
	output logic      [2:0]           pin_out_q,
	output logic      [2:0]           pin_oe_q,
	output logic      [2:0]           pullup_en_q,
	// System pin-select bits
	input  wire logic                 phase_b_alt_select,
	input  wire logic                 select_a,
	input  wire logic                 select_b,
	// Port C control
	input  wire logic [DPM_PUR_W-1:0] port_c_pullup_reg,
	input  wire logic [2:0]           port_c_periph_en,
	input  wire logic [2:0]           port_c_dir_out,
	input  wire logic [2:0]           port_c_io_out,
	output logic      [2:0]           port_c_io_in_q,
	// Timer B channels 1..3
	input  wire logic [2:0]           timer_select,
	input  wire logic [2:0]           timer_b_out,
	input  wire logic [2:0]           timer_b_oe,
	output logic      [2:0]           timer_b_in_q,
	// Decoder 1 inputs
	output logic                      decoder1_phase_b_in_q,
	output logic                      decoder1_index_in_q,
	output logic                      decoder1_home_in_q,
	// SPI port 2
	input  wire logic                 spi2_master_mode,
	input  wire logic                 spi2_master_out_tx,
	input  wire logic                 spi2_master_in_tx,
	output logic                      spi2_master_out_rx_q,
	output logic                      spi2_master_in_rx_q,
	output logic                      spi2_slave_select_rx_q,
	output logic                      spi2_slave_selected_q,
	output logic                      spi2_mode_fault_q
);

	// Alt-select bits gathered per pin
	wire logic [2:0] alt_w = {select_b, select_a, phase_b_alt_select};
	// Function per pin, from the cells
	dpm_fn_e         fn_w [DPM_NUM_PINS];
	// Cell drive results
	logic      [2:0] cell_out_w;
	logic      [2:0] cell_oe_w;
	// SPI drive per pin
	logic      [2:0] spi_out_w;
	logic      [2:0] spi_oe_w;
	// Per-pin routed receive values
	logic      [2:0] dec_rx_w;
	logic      [2:0] tim_rx_w;
	logic      [2:0] gpio_rx_w;
	logic      [2:0] spi_rx_w;

	// select pin sensed only when routed
	wire logic ss_low_w   = alt_w[DPM_PIN_HOME] && (pin_in[DPM_PIN_HOME] == DPM_SS_ACTIVE);
	wire logic slv_sel_w  = !spi2_master_mode && ss_low_w;
	wire logic fault_w    = spi2_master_mode && ss_low_w;

	// master-out driven only by a master
	assign spi_out_w[DPM_PIN_PHASE_B] = spi2_master_out_tx;
	assign spi_oe_w[DPM_PIN_PHASE_B]  = spi2_master_mode;
	// slave drives master-in only when selected
	assign spi_out_w[DPM_PIN_INDEX]   = spi2_master_in_tx;
	assign spi_oe_w[DPM_PIN_INDEX]    = slv_sel_w;
	// slave select is always an input
	assign spi_out_w[DPM_PIN_HOME]    = DPM_DRV_OFF;
	assign spi_oe_w[DPM_PIN_HOME]     = DPM_DRV_OFF;

	// One cell per pin; receive values are handed only to the chosen function
	genvar gi;
	generate
		for (gi = 0; gi < DPM_NUM_PINS; gi++) begin : g_pin
			dpm_pin_cell #(
				.FULL_FEATURED (FULL_FEATURED)
			) u_cell (
				.alt_select   (alt_w[gi]),
				.periph_en    (port_c_periph_en[gi]),
				.timer_select (timer_select[gi]),
				.gpio_out     (port_c_io_out[gi]),
				.gpio_dir_out (port_c_dir_out[gi]),
				.timer_out    (timer_b_out[gi]),
				.timer_oe     (timer_b_oe[gi]),
				.spi_out      (spi_out_w[gi]),
				.spi_oe       (spi_oe_w[gi]),
				.fn           (fn_w[gi]),
				.pin_out      (cell_out_w[gi]),
				.pin_oe       (cell_oe_w[gi])
			);
			assign dec_rx_w[gi]  = (fn_w[gi] == DPM_FN_DECODER) ? pin_in[gi] : DPM_RX_IDLE;
			assign tim_rx_w[gi]  = (fn_w[gi] == DPM_FN_TIMER)   ? pin_in[gi] : DPM_RX_IDLE;
			assign gpio_rx_w[gi] = (fn_w[gi] == DPM_FN_GPIO)    ? pin_in[gi] : DPM_RX_IDLE;
			assign spi_rx_w[gi]  = (fn_w[gi] == DPM_FN_SPI)     ? pin_in[gi] : DPM_RX_IDLE;
		end
	endgenerate

	// Pad drive registers; enables come up off so nothing fights the pad at reset
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_out_q <= DPM_PIN_OUT_RST;
			pin_oe_q  <= DPM_PIN_OE_RST;
		end else begin
			pin_out_q <= cell_out_w;
			pin_oe_q  <= cell_oe_w;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pullup_en_q <= DPM_PULL_RST;
		end else begin
			pullup_en_q <= port_c_pullup_reg[DPM_PUR_LSB +: DPM_NUM_PINS];
		end
	end

	// Receive registers for timer and GPIO
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			timer_b_in_q   <= DPM_RX_IDLE_V;
			port_c_io_in_q <= DPM_RX_IDLE_V;
		end else begin
			timer_b_in_q   <= tim_rx_w;
			port_c_io_in_q <= gpio_rx_w;
		end
	end

	// Decoder inputs; the reduced variant never passes the pin through
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			decoder1_phase_b_in_q <= DPM_RX_IDLE;
			decoder1_index_in_q   <= DPM_RX_IDLE;
			decoder1_home_in_q    <= DPM_RX_IDLE;
		end else begin
			decoder1_phase_b_in_q <= dec_rx_w[DPM_PIN_PHASE_B];
			decoder1_index_in_q   <= dec_rx_w[DPM_PIN_INDEX];
			decoder1_home_in_q    <= dec_rx_w[DPM_PIN_HOME];
		end
	end

	// same fixed delay on master-in
	// Both directions pass one flop, so the half-cycle lead the core sets is kept
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			spi2_master_out_rx_q   <= DPM_RX_IDLE;
			spi2_master_in_rx_q    <= DPM_RX_IDLE;
			spi2_slave_select_rx_q <= DPM_RX_IDLE;
			spi2_slave_selected_q  <= DPM_DRV_OFF;
			spi2_mode_fault_q      <= DPM_DRV_OFF;
		end else begin
			spi2_master_out_rx_q   <= spi_rx_w[DPM_PIN_PHASE_B];
			spi2_master_in_rx_q    <= spi_rx_w[DPM_PIN_INDEX];
			spi2_slave_select_rx_q <= spi_rx_w[DPM_PIN_HOME];
			spi2_slave_selected_q  <= slv_sel_w;
			spi2_mode_fault_q      <= fault_w;
		end
	end

	// Checks on the routing; all in the one clock domain
	default clocking dpm_cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_mosi_route: assert property (phase_b_alt_select && spi2_master_mode
		|=> pin_oe_q[DPM_PIN_PHASE_B] && (pin_out_q[DPM_PIN_PHASE_B] == $past(spi2_master_out_tx)))
		else $error("master-out not driven on phase B pin");

	a_miso_route: assert property (select_a && spi2_master_mode
		|=> !pin_oe_q[DPM_PIN_INDEX] && (spi2_master_in_rx_q == $past(pin_in[DPM_PIN_INDEX])))
		else $error("master-in not taken from index pin");

	a_miso_release: assert property (select_a && !spi2_master_mode
		&& !(select_b && pin_in[DPM_PIN_HOME] == DPM_SS_ACTIVE) |=> !pin_oe_q[DPM_PIN_INDEX])
		else $error("unselected slave drives master-in");

	// slave select is input from home
	a_ss_route: assert property (select_b
		|=> !pin_oe_q[DPM_PIN_HOME] && (spi2_slave_select_rx_q == $past(pin_in[DPM_PIN_HOME])))
		else $error("slave select not routed from home pin");

	a_ss_roles: assert property (!(spi2_slave_selected_q && spi2_mode_fault_q)
		&& (spi2_mode_fault_q == $past(spi2_master_mode && select_b
		&& pin_in[DPM_PIN_HOME] == DPM_SS_ACTIVE)))
		else $error("slave select role wrong");

	a_dec_default: assert property (FULL_FEATURED && !phase_b_alt_select
		&& port_c_periph_en[DPM_PIN_PHASE_B] && !timer_select[DPM_PIN_PHASE_B]
		|=> !pin_oe_q[DPM_PIN_PHASE_B]
		&& (decoder1_phase_b_in_q == $past(pin_in[DPM_PIN_PHASE_B])))
		else $error("decoder phase B input not routed");

	a_pull_track: assert property (##1 pullup_en_q
		== $past(port_c_pullup_reg[DPM_PUR_LSB +: DPM_NUM_PINS]))
		else $error("pull-up enable does not follow register");

	a_gpio_dir: assert property (!select_a && !port_c_periph_en[DPM_PIN_INDEX]
		|=> (pin_oe_q[DPM_PIN_INDEX] == $past(port_c_dir_out[DPM_PIN_INDEX]))
		&& (pin_out_q[DPM_PIN_INDEX] == $past(port_c_io_out[DPM_PIN_INDEX])))
		else $error("GPIO direction not honoured");

	a_timer_route: assert property (!select_b && port_c_periph_en[DPM_PIN_HOME]
		&& timer_select[DPM_PIN_HOME]
		|=> (pin_oe_q[DPM_PIN_HOME] == $past(timer_b_oe[DPM_PIN_HOME]))
		&& (timer_b_in_q[DPM_PIN_HOME] == $past(pin_in[DPM_PIN_HOME])))
		else $error("timer channel not routed");

	// clear alt bit gives SPI nothing
	a_alt_clear: assert property (!phase_b_alt_select
		|=> spi2_master_out_rx_q == DPM_RX_IDLE)
		else $error("SPI sees phase B pin with alt clear");

endmodule // dpm_pin_mux

// >>> sim/dpm_pad_model.sv
// Purpose: Pad and far-side model for the three multiplexed pins.
// Assumes: Far-side parties drive only through ext_oe and ext_val.
// Notes:   An undriven pin without pull-up toggles every clock, so no stale value survives.
module dpm_pad_model (
	input  wire logic       clock,
	input  wire logic [2:0] pin_out_q,
	input  wire logic [2:0] pin_oe_q,
	input  wire logic [2:0] pullup_en_q,
	input  wire logic [2:0] ext_val,
	input  wire logic [2:0] ext_oe,
	output logic      [2:0] pin_level
);
	timeunit 1ns;
	timeprecision 100ps;
	logic float_q = 1'b0;  // Floating-pin pattern

	// Floating level changes each cycle
	always @(posedge clock) begin
		float_q <= ~float_q;
	end

	// Wire resolution per pin; device drive wins, then far side, then pull-up
	// pull-up holds level
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (pin_oe_q[i])
				pin_level[i] = pin_out_q[i];
			else if (ext_oe[i])
				pin_level[i] = ext_val[i];
			else
				pin_level[i] = pullup_en_q[i] ? 1'b1 : float_q;
		end
	end
endmodule // dpm_pad_model

// >>> sim/dpm_pin_mux_test.sv
// Purpose: Self-checking bench for the decoder 1 pin multiplexer.
// Assumes: Full-featured variant; inputs change 1 ns after the rising edge.
// Notes:   A reduced-variant instance runs beside the full one on the same inputs.
module dpm_pin_mux_test;
	timeunit 1ns;
	timeprecision 100ps;
	import dpm_pkg::*;
	logic       clock = 1'b0;
	logic       reset_n = 1'b0;
	logic [2:0] pin_in, pin_out_q, pin_oe_q, pullup_en_q, port_c_io_in_q, timer_b_in_q;
	logic [2:0] ext_val = 3'h0, ext_oe = 3'h0;  // Far-side drive
	logic       alt_mo = 1'b0, alt_mi = 1'b0, alt_ss = 1'b0, master = 1'b0;
	logic       mo_tx = 1'b0, mi_tx = 1'b0;
	logic [3:0] pur = 4'hf;
	logic [2:0] periph = 3'h7, dir = 3'h0, io_out = 3'h0;
	logic [2:0] tsel = 3'h0, t_out = 3'h0, t_oe = 3'h0;
	logic       dec_b, dec_i, dec_h, mo_rx, mi_rx, ss_rx, sel, fault;
	logic [2:0] r_oe, r_io_in;               // Reduced variant results
	logic       r_dec_b, r_dec_i, r_dec_h;
	int         error_cnt = 0, check_count = 0, cycles = 0;

	// Clock at 125 MHz
	always #4 clock = ~clock;

	dpm_pin_mux uut (.clock(clock), .reset_n(reset_n), .pin_in(pin_in),
		.pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .pullup_en_q(pullup_en_q),
		.phase_b_alt_select(alt_mo), .select_a(alt_mi), .select_b(alt_ss),
		.port_c_pullup_reg(pur), .port_c_periph_en(periph), .port_c_dir_out(dir),
		.port_c_io_out(io_out), .port_c_io_in_q(port_c_io_in_q), .timer_select(tsel),
		.timer_b_out(t_out), .timer_b_oe(t_oe), .timer_b_in_q(timer_b_in_q),
		.decoder1_phase_b_in_q(dec_b), .decoder1_index_in_q(dec_i),
		.decoder1_home_in_q(dec_h), .spi2_master_mode(master),
		.spi2_master_out_tx(mo_tx), .spi2_master_in_tx(mi_tx),
		.spi2_master_out_rx_q(mo_rx), .spi2_master_in_rx_q(mi_rx),
		.spi2_slave_select_rx_q(ss_rx), .spi2_slave_selected_q(sel),
		.spi2_mode_fault_q(fault));

	dpm_pad_model pads (.clock(clock), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q),
		.pullup_en_q(pullup_en_q), .ext_val(ext_val), .ext_oe(ext_oe),
		.pin_level(pin_in));

	// Reduced variant, fed the same inputs and pad levels as the full one
	dpm_pin_mux #(.FULL_FEATURED(1'b0)) uut_red (.clock(clock), .reset_n(reset_n),
		.pin_in(pin_in), .pin_out_q(), .pin_oe_q(r_oe), .pullup_en_q(),
		.phase_b_alt_select(alt_mo), .select_a(alt_mi), .select_b(alt_ss),
		.port_c_pullup_reg(pur), .port_c_periph_en(periph), .port_c_dir_out(dir),
		.port_c_io_out(io_out), .port_c_io_in_q(r_io_in), .timer_select(tsel),
		.timer_b_out(t_out), .timer_b_oe(t_oe), .timer_b_in_q(),
		.decoder1_phase_b_in_q(r_dec_b), .decoder1_index_in_q(r_dec_i),
		.decoder1_home_in_q(r_dec_h), .spi2_master_mode(master),
		.spi2_master_out_tx(mo_tx), .spi2_master_in_tx(mi_tx),
		.spi2_master_out_rx_q(), .spi2_master_in_rx_q(),
		.spi2_slave_select_rx_q(), .spi2_slave_selected_q(),
		.spi2_mode_fault_q());

	// Compare one result, up to three bits wide
	task automatic chk(input logic [2:0] got, input logic [2:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Let n edges pass, then settle just after the last one
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Counts and verdict, then end of run
	task automatic conclude();
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Hang guard; about 30 cycles are expected
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			error_cnt++;
			conclude();
		end
	end

	initial begin
		step(1);
		chk(pullup_en_q, 3'h7);
		chk(pin_oe_q, 3'h0);
		step(7);
		reset_n = 1'b1;
		// Decoder default with far side driving all pins
		ext_oe = 3'h7;
		ext_val = 3'h5;
		step(2);
		chk({dec_h, dec_i, dec_b}, 3'h5);
		chk(pin_oe_q, 3'h0);
		// Reduced variant default offers no function: no drive, decoder idle
		chk({r_dec_h, r_dec_i, r_dec_b}, 3'h7);
		chk(r_oe, 3'h0);
		// Pull-up disable, one bit at a time
		ext_oe = 3'h0;
		for (int i = 0; i < 3; i++) begin
			pur = 4'hf ^ (4'h2 << i);
			step(1);
			chk(pullup_en_q, 3'h7 ^ (3'h1 << i));
		end
		pur = 4'h1;
		step(1);
		chk(pullup_en_q, 3'h0);
		pur = 4'hf;
		// GPIO: pins 0 and 2 out, pin 1 in
		periph = 3'h0;
		dir = 3'h5;
		io_out = 3'h1;
		ext_oe = 3'h2;
		ext_val = 3'h2;
		step(2);
		chk(pin_oe_q, 3'h5);
		chk(pin_out_q & 3'h5, 3'h1);
		chk(port_c_io_in_q, 3'h3);
		// Software has reconfigured the reduced variant to GPIO as well
		chk(r_oe, 3'h5);
		chk(r_io_in, 3'h3);
		// Timer channels: 1 and 2 drive, 3 receives
		periph = 3'h7;
		tsel = 3'h7;
		t_oe = 3'h3;
		t_out = 3'h2;
		ext_oe = 3'h4;
		ext_val = 3'h0;
		step(2);
		chk(pin_oe_q, 3'h3);
		chk(pin_out_q & 3'h3, 3'h2);
		chk(timer_b_in_q, 3'h2);
		chk({dec_h, dec_i, dec_b}, 3'h7);
		tsel = 3'h0;
		t_oe = 3'h0;
		// SPI master: master-out driven on pin 0, far slave answers on pin 1
		master = 1'b1;
		alt_mo = 1'b1;
		alt_mi = 1'b1;
		mo_tx = 1'b1;
		ext_oe = 3'h6;
		ext_val = 3'h4;
		step(1);
		chk(pin_oe_q, 3'h1);
		chk(pin_out_q[0], 1'b1);
		mo_tx = 1'b0;
		step(1);
		chk(pin_out_q[0], 1'b0);
		step(1);
		chk(mi_rx, 1'b0);
		// Another master pulls slave select low
		alt_ss = 1'b1;
		ext_val = 3'h2;
		step(2);
		chk(fault, 1'b1);
		chk(mi_rx, 1'b1);
		// SPI slave, selected, then released
		master = 1'b0;
		mi_tx = 1'b1;
		ext_oe = 3'h5;
		ext_val = 3'h1;
		step(2);
		chk(pin_oe_q, 3'h2);
		chk(pin_out_q[1], 1'b1);
		chk({sel, ss_rx, mo_rx}, 3'h5);
		chk(fault, 1'b0);
		ext_val = 3'h4;
		step(2);
		chk(pin_oe_q, 3'h0);
		chk({sel, ss_rx, mo_rx}, 3'h2);
		// Alt bits cleared hand pins back
		alt_mo = 1'b0;
		alt_mi = 1'b0;
		alt_ss = 1'b0;
		ext_oe = 3'h7;
		ext_val = 3'h3;
		step(2);
		chk({dec_h, dec_i, dec_b}, 3'h3);
		chk({sel, mi_rx, mo_rx}, 3'h3);
		conclude();
	end
endmodule // dpm_pin_mux_test
